// ### ppd_pkg.sv
// package: constants, register map and carrier types of the power-down block
package ppd_pkg;

  // ****************************************
  // sizes
  // ****************************************
  localparam int unsigned NUM_IO = 8;

  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [11:0] OFF_CFG    = 12'h000;
  localparam logic [11:0] OFF_SLEW   = 12'h004;
  localparam logic [11:0] OFF_RPWR   = 12'h008;
  localparam logic [11:0] OFF_OUTDAT = 12'h00c;
  localparam logic [11:0] OFF_OUTEN  = 12'h010;
  localparam logic [11:0] OFF_INDAT  = 12'h014;
  localparam logic [11:0] OFF_STATUS = 12'h018;

  // ****************************************
  // cfg field positions
  // ****************************************
  localparam int unsigned CFG_PD_EN_BIT  = 0;
  localparam int unsigned CFG_PU_TMS_BIT = 1;
  localparam int unsigned CFG_PU_TDI_BIT = 2;

  // status field positions
  localparam int unsigned ST_ASLEEP_BIT = 0;
  localparam int unsigned ST_WAKING_BIT = 1;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [2:0]        CFG_RST  = 3'h0;
  localparam logic [NUM_IO-1:0] SLEW_RST = '0; // 0 = slow switching
  localparam logic [NUM_IO-1:0] RPWR_RST = '0;
  localparam logic [NUM_IO-1:0] ODAT_RST = '0;
  localparam logic [NUM_IO-1:0] OEN_RST  = '0;

  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_MHZ        = 125;
  localparam int unsigned WAKE_TIME_US   = 1;
  localparam int unsigned WAKE_CYC       = WAKE_TIME_US * CLK_MHZ;
  localparam int unsigned RPA_TIME_NS    = 10;
  localparam int unsigned CLK_PERIOD_NS  = 8;
  localparam int unsigned RPA_CYC        =
    (RPA_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0]  WAKE_CYC_W     = 8'(WAKE_CYC);
  localparam logic [1:0]  RPA_CYC_W      = 2'(RPA_CYC);

  // ****************************************
  // states and carriers
  // ****************************************
  typedef enum logic [2:0] {
    PPD_RUN   = 3'b001,
    PPD_SLEEP = 3'b010,
    PPD_WAKE  = 3'b100
  } ppd_state_t;

  typedef struct packed {
    logic [NUM_IO-1:0] dat;
    logic [NUM_IO-1:0] oe;
    logic [NUM_IO-1:0] fast;
  } ppd_pins_t;

endpackage : ppd_pkg

// ### ppd_top.sv
// pin-controlled power-down block with apb configuration
//
// Contract
// R1 - with power-down enabled, either sleep pin high enters power-down
// R2 - entering power-down holds internal state and enabled outputs
// R3 - while asleep every pin except the sleep pins is ignored
// R4 - sleep pins are not logic i/o; buried macrocell logic remains usable
// R5 - outputs in high-z at entry stay high-z throughout power-down
// R6 - input hold latches stay active during power-down
// R7 - power-down exists only when enabled; otherwise sleep pins are plain i/o
// R8 - each output has its own slew bit, slow by default
// R9 - each cell has a reduced-power bit adding a fixed delay
// R10 - after sleep pins fall, full operation returns within one microsecond
// R11 - mode-select and data-in test pins each have optional pull-up
// R12 - leaving power-down resumes from held state without reinitialising
`timescale 1ns/1ps
`default_nettype none
module ppd_top
  import ppd_pkg::*;
(
  // clock and reset
  input  wire  logic                      pclk,
  input  wire  logic                      presetn,
  // apb slave
  input  wire  logic                      psel,
  input  wire  logic                      penable,
  input  wire  logic                      pwrite,
  input  wire  logic [11:0]               paddr,
  input  wire  logic [31:0]               pwdata,
  output var   logic [31:0]               prdata,
  output var   logic                      pready,
  output var   logic                      pslverr,
  // sleep pins, two-way when not used for power-down
  input  wire  logic                      sleep_pin_a_i,
  output var   logic                      sleep_pin_a_o,
  output var   logic                      sleep_pin_a_oe,
  input  wire  logic                      sleep_pin_b_i,
  output var   logic                      sleep_pin_b_o,
  output var   logic                      sleep_pin_b_oe,
  // user i/o pins
  input  wire  logic [ppd_pkg::NUM_IO-1:0] io_i,
  output var   ppd_pkg::ppd_pins_t         io_pins,
  // test-port pull-up enables
  output var   logic                      tms_pullup_en,
  output var   logic                      tdi_pullup_en,
  // status
  output var   logic                      asleep,
  output var   logic [ppd_pkg::NUM_IO-1:0] rpwr_delayed
);
  import ppd_pkg::*;

  // ****************************************
  // registers
  // ****************************************
  logic [2:0]        cfg_reg;
  logic [NUM_IO-1:0] slew_reg;
  logic [NUM_IO-1:0] rpwr_reg;
  logic [NUM_IO-1:0] odat_reg;
  logic [NUM_IO-1:0] oen_reg;
  logic [NUM_IO-1:0] in_hold_reg;
  logic              pina_reg;
  logic              pinb_reg;
  ppd_state_t        state_reg;
  ppd_state_t        state_next;
  logic [7:0]        wake_cnt_reg;
  logic [1:0]        rpa_cnt_reg [NUM_IO];

  logic pd_en;
  logic sleep_req;
  logic frozen;
  logic wr_en;
  logic rd_en;
  logic addr_ok;

  function automatic logic map_hit(input logic [11:0] a);
    unique case (a)
      OFF_CFG, OFF_SLEW, OFF_RPWR, OFF_OUTDAT,
      OFF_OUTEN, OFF_INDAT, OFF_STATUS: map_hit = 1'b1;
      default:                          map_hit = 1'b0;
    endcase
  endfunction : map_hit

  assign pd_en     = cfg_reg[CFG_PD_EN_BIT];
  assign sleep_req = pd_en & (sleep_pin_a_i | sleep_pin_b_i); // R1
  assign frozen    = (state_reg == PPD_SLEEP);
  assign wr_en     = psel & penable & pwrite;
  assign rd_en     = psel & ~penable & ~pwrite;
  assign addr_ok   = map_hit(paddr);

  // ****************************************
  // power-down state machine
  // ****************************************
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      PPD_RUN: begin
        if (sleep_req) begin
          state_next = PPD_SLEEP; // R1
        end
      end
      PPD_SLEEP: begin
        if (!sleep_req) begin
          state_next = PPD_WAKE;
        end
      end
      PPD_WAKE: begin
        if (sleep_req) begin
          state_next = PPD_SLEEP;
        end else if (wake_cnt_reg == 8'h01) begin
          state_next = PPD_RUN; // R10
        end
      end
      default: state_next = PPD_RUN;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= PPD_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // wake-up count, WAKE_CYC cycles, exactly one microsecond at CLK_MHZ
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_cnt_reg <= 8'h00;
    end else if (state_reg == PPD_SLEEP) begin
      wake_cnt_reg <= WAKE_CYC_W; // R10
    end else if (wake_cnt_reg != 8'h00) begin
      wake_cnt_reg <= wake_cnt_reg - 8'h01;
    end
  end

  // ****************************************
  // apb register writes
  // ****************************************
  // config stays writable while asleep; it is not a pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg  <= CFG_RST;
      slew_reg <= SLEW_RST;
      rpwr_reg <= RPWR_RST;
    end else if (wr_en) begin
      unique case (paddr)
        OFF_CFG:  cfg_reg  <= pwdata[2:0];           // R7 R11
        OFF_SLEW: slew_reg <= pwdata[NUM_IO-1:0];    // R8
        OFF_RPWR: rpwr_reg <= pwdata[NUM_IO-1:0];    // R9
        default: ;
      endcase
    end
  end

  // logic state held while frozen, kept on release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      odat_reg <= ODAT_RST;
      oen_reg  <= OEN_RST;
    end else if (wr_en && !frozen) begin // R2 R12
      unique case (paddr)
        OFF_OUTDAT: odat_reg <= pwdata[NUM_IO-1:0];
        OFF_OUTEN:  oen_reg  <= pwdata[NUM_IO-1:0];
        default: ;
      endcase
    end
  end

  // ****************************************
  // input hold latches
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_hold_reg <= '0;
    end else if (!frozen && !sleep_req) begin // R3 R6
      in_hold_reg <= io_i;
    end
  end

  // sleep pin levels read back only while they are plain i/o
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pina_reg <= 1'b0;
      pinb_reg <= 1'b0;
    end else if (!frozen && !sleep_req) begin
      pina_reg <= ~pd_en & sleep_pin_a_i; // R4
      pinb_reg <= ~pd_en & sleep_pin_b_i; // R4
    end
  end

  // ****************************************
  // reduced-power delay per cell
  // ****************************************
  // a reduced-power cell lags its plain copy by the adder count
  for (genvar g = 0; g < NUM_IO; g++) begin : g_rpa
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        rpa_cnt_reg[g]  <= 2'h0;
        rpwr_delayed[g] <= 1'b0;
      end else if (frozen) begin
        rpa_cnt_reg[g]  <= rpa_cnt_reg[g];
      end else if (odat_reg[g] == rpwr_delayed[g]) begin
        rpa_cnt_reg[g]  <= rpwr_reg[g] ? RPA_CYC_W : 2'h0; // R9
      end else if (rpa_cnt_reg[g] == 2'h0) begin
        rpwr_delayed[g] <= odat_reg[g];
        rpa_cnt_reg[g]  <= 2'h0;
      end else begin
        rpa_cnt_reg[g]  <= rpa_cnt_reg[g] - 2'h1;
      end
    end
  end

  // ****************************************
  // pin drivers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io_pins <= '0;
    end else begin
      if (!frozen && !sleep_req) begin // R2 R5
        io_pins.dat <= odat_reg;
        io_pins.oe  <= oen_reg;
      end
      io_pins.fast <= slew_reg; // R8
    end
  end

  // sleep pins double as i/o bit 0 and 1 when power-down is off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_pin_a_o  <= 1'b0;
      sleep_pin_a_oe <= 1'b0;
      sleep_pin_b_o  <= 1'b0;
      sleep_pin_b_oe <= 1'b0;
    end else begin
      sleep_pin_a_o  <= odat_reg[0];
      sleep_pin_a_oe <= ~pd_en & oen_reg[0]; // R4 R7
      sleep_pin_b_o  <= odat_reg[1];
      sleep_pin_b_oe <= ~pd_en & oen_reg[1]; // R4 R7
    end
  end

  // test-port pull-ups follow the config bits, never gated by sleep
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tms_pullup_en <= 1'b0;
      tdi_pullup_en <= 1'b0;
    end else begin
      tms_pullup_en <= cfg_reg[CFG_PU_TMS_BIT]; // R11
      tdi_pullup_en <= cfg_reg[CFG_PU_TDI_BIT]; // R11
    end
  end

  // asleep rises on the edge that enters the sleep state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      asleep <= 1'b0;
    end else begin
      asleep <= (state_next == PPD_SLEEP); // R1
    end
  end

  // ****************************************
  // apb read and answer
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      // ready answers every setup, no wait states
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~addr_ok;
    end
  end

  // read data stands only in the access cycle, zero otherwise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= 32'h0000_0000;
      if (rd_en) begin
        unique case (paddr)
          OFF_CFG:    prdata <= {29'h0, cfg_reg};
          OFF_SLEW:   prdata <= {24'h0, slew_reg};
          OFF_RPWR:   prdata <= {24'h0, rpwr_reg};
          OFF_OUTDAT: prdata <= {24'h0, odat_reg};
          OFF_OUTEN:  prdata <= {24'h0, oen_reg};
          OFF_INDAT:  prdata <= {22'h0, pinb_reg, pina_reg, in_hold_reg};
          OFF_STATUS: prdata <= {30'h0,
                                 state_reg == PPD_WAKE,
                                 frozen};
          default:    prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule : ppd_top
`default_nettype wire

// ### ppd_sleep_drv.sv
// system logic model driving the two sleep pins
`timescale 1ns/1ps
`default_nettype none
module ppd_sleep_drv (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // requests from the bench
  input  wire logic want_a,
  input  wire logic want_b,
  // sleep pins
  output var  logic pin_a,
  output var  logic pin_b
);
  // pins move just after an edge, low through reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_a <= 1'b0;
      pin_b <= 1'b0;
    end else begin
      pin_a <= want_a;
      pin_b <= want_b;
    end
  end
endmodule : ppd_sleep_drv
`default_nettype wire

// ### ppd_checker.sv
// port assertions of the power-down block
`timescale 1ns/1ps
`default_nettype none
module ppd_checker
  import ppd_pkg::*;
(
  // clock and reset
  input wire logic               pclk,
  input wire logic               presetn,
  // apb
  input wire logic               psel,
  input wire logic               penable,
  input wire logic [31:0]        prdata,
  input wire logic               pready,
  input wire logic               pslverr,
  // pins
  input wire logic               sleep_pin_a_i,
  input wire logic               sleep_pin_b_i,
  input wire logic               sleep_pin_a_oe,
  input wire logic               sleep_pin_b_oe,
  input wire ppd_pkg::ppd_pins_t io_pins,
  input wire logic               asleep
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_entry_cause: assert property ($rose(asleep) |->
    $past(sleep_pin_a_i || sleep_pin_b_i)) else $error("sleep without pin");
  chk_stay_asleep: assert property (asleep &&
    (sleep_pin_a_i || sleep_pin_b_i) |=> asleep) else $error("woke early");
  chk_wake_exit: assert property (asleep && !sleep_pin_a_i &&
    !sleep_pin_b_i |=> !asleep) else $error("stuck asleep");
  chk_dat_frozen: assert property (asleep |->
    $stable(io_pins.dat)) else $error("data moved asleep");
  chk_oe_frozen: assert property (asleep |->
    $stable(io_pins.oe)) else $error("enable moved asleep");
  chk_pins_freed: assert property (asleep |->
    !sleep_pin_a_oe && !sleep_pin_b_oe) else $error("sleep pin driven");
  chk_zero_wait: assert property (psel && penable |-> pready)
    else $error("no ready");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  chk_idle_rdata: assert property (!pready |-> prdata == 32'h0)
    else $error("stray read data");
endmodule : ppd_checker

bind ppd_top ppd_checker ppd_checker_i (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .sleep_pin_a_i(sleep_pin_a_i),
  .sleep_pin_b_i(sleep_pin_b_i), .sleep_pin_a_oe(sleep_pin_a_oe),
  .sleep_pin_b_oe(sleep_pin_b_oe), .io_pins(io_pins), .asleep(asleep));
`default_nettype wire

// ### test_pin_controlled_power_down.sv
// self-checking bench of the power-down block
`timescale 1ns/1ps
`default_nettype none
module test_pin_controlled_power_down;
  import ppd_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic a_o, a_oe, b_o, b_oe, pin_a, pin_b, want_a, want_b;
  logic tms_pu, tdi_pu, asleep;
  logic [NUM_IO-1:0] io_i, rpd;
  ppd_pins_t io_pins;
  int num_errors = 0;
  int n_tests = 0;
  // pin a level: design drives it only with its enable up
  wire logic a_w = a_oe ? a_o : pin_a;

  ppd_top ppd_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sleep_pin_a_i(a_w), .sleep_pin_a_o(a_o), .sleep_pin_a_oe(a_oe),
    .sleep_pin_b_i(pin_b), .sleep_pin_b_o(b_o), .sleep_pin_b_oe(b_oe),
    .io_i(io_i), .io_pins(io_pins), .tms_pullup_en(tms_pu),
    .tdi_pullup_en(tdi_pu), .asleep(asleep), .rpwr_delayed(rpd));
  ppd_sleep_drv ppd_sleep_drv_i (.pclk(pclk), .presetn(presetn),
    .want_a(want_a), .want_b(want_b), .pin_a(pin_a), .pin_b(pin_b));

  // ********
  // helpers
  // ********
  task automatic chk(input string nm, input logic [31:0] ex, got);
    n_tests++;
    if (got !== ex) begin
      num_errors++;
      $display("[ERR] %s exp %h got %h", nm, ex, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    chk("wr_err", 0, e);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] ex,
                    input logic ee);
    apb(1'b0, a, 32'h0);
    chk("rdata", ex, r);
    chk("rd_err", ee, e);
  endtask : rd
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : tick
  task automatic close_out();
    if (num_errors == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out

  // ********
  // scenarios
  // ********
  task automatic t_reset();
    chk("fast", 0, io_pins.fast);
    chk("pullups_off", 0, {tms_pu, tdi_pu});
    for (int i = 0; i < 7; i++) rd(12'(4 * i), 0, 1'b0);
    rd(12'h01c, 0, 1'b1);
    apb(1'b1, 12'h01c, 32'h1);
    chk("wr_unmapped", 1, e);
  endtask : t_reset
  task automatic t_plain();
    wr(OFF_OUTDAT, 32'h3);
    wr(OFF_OUTEN, 32'h1);
    tick(2);
    chk("pin_a_oe", 1, a_oe);
    chk("pin_a_o", 1, a_o);
    chk("pin_b_oe", 0, b_oe);
    chk("pin_b_o", 1, b_o);
    @(posedge pclk);
    want_b <= 1'b1;
    tick(4);
    chk("asleep", 0, asleep);
    rd(OFF_INDAT, 32'h300, 1'b0);
    @(posedge pclk);
    want_b <= 1'b0;
    wr(OFF_OUTEN, 32'h0);
  endtask : t_plain
  task automatic t_sleep(input logic sel);
    wr(OFF_CFG, 32'h7);
    tick(1);
    chk("pullups", 2'b11, {tms_pu, tdi_pu});
    chk("pin_a_freed", 0, a_oe);
    wr(OFF_OUTDAT, 32'ha5);
    wr(OFF_OUTEN, 32'h0f);
    @(posedge pclk);
    io_i <= 8'h3c;
    want_a <= !sel;
    want_b <= sel;
    tick(2);
    chk("asleep", 1, asleep);
    @(posedge pclk);
    io_i <= 8'hc3;
    wr(OFF_OUTDAT, 32'h5a);
    wr(OFF_OUTEN, 32'hff);
    chk("dat_held", 8'ha5, io_pins.dat);
    chk("oe_held", 8'h0f, io_pins.oe);
    apb(1'b0, OFF_INDAT, 32'h0);
    chk("in_held", 8'h3c, r[7:0]);
    rd(OFF_STATUS, 32'h1, 1'b0);
    @(posedge pclk);
    want_a <= 1'b0;
    want_b <= 1'b0;
    tick(2);
    chk("awake", 0, asleep);
    chk("dat_resume", 8'ha5, io_pins.dat);
    rd(OFF_STATUS, 32'h2, 1'b0);
    rd(OFF_INDAT, 32'hc3, 1'b0);
    wr(OFF_OUTDAT, 32'h5a);
    tick(2);
    chk("dat_live", 8'h5a, io_pins.dat);
    tick(WAKE_CYC);
    rd(OFF_STATUS, 32'h0, 1'b0);
  endtask : t_sleep
  task automatic t_slew();
    int n;
    wr(OFF_SLEW, 32'h81);
    tick(2);
    chk("fast", 8'h81, io_pins.fast);
    wr(OFF_RPWR, 32'h1);
    wr(OFF_OUTDAT, 32'ha5);
    n = 0;
    while (rpd[1] !== 1'b0 && n < 8) begin
      tick(1);
      n++;
    end
    chk("rpd1_plain", 1, n);
    tick(RPA_CYC - 1);
    chk("rpd0_lag", 0, rpd[0]);
    tick(1);
    chk("rpd0_late", 1, rpd[0]);
  endtask : t_slew

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  initial begin
    #400000;
    num_errors++;
    close_out();
  end
  initial begin
    {presetn, psel, penable, pwrite, want_a, want_b} = '0;
    paddr = '0;
    pwdata = '0;
    io_i = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    tick(1);
    t_reset();
    t_plain();
    t_sleep(1'b0);
    t_sleep(1'b1);
    t_slew();
    close_out();
  end
endmodule : test_pin_controlled_power_down
`default_nettype wire
